//--- common/ast_defs.vh
`ifndef AST_DEFS_VH
`define AST_DEFS_VH

// baud generator
`define AST_DIV_W          13
`define AST_OVERSAMPLE_MAX 4'hF

// frame lengths in bit times (start + data + stop)
`define AST_FRAME8_BITS    4'hA
`define AST_FRAME9_BITS    4'hB

// frame field positions: start and data LSB inside the 11-bit shifter image, parity inside the 9-bit data character
`define AST_START_POS      0
`define AST_DATA_LSB_POS   1
`define AST_PAR8_POS       7
`define AST_PAR9_POS       8

// line levels
`define AST_MARK           1'b1
`define AST_SPACE          1'b0

// reset values of the status flags
`define AST_TX_BUFFER_EMPTY_FLAG_RST       1'b1
`define AST_TC_RST         1'b1

// shifter images for the special characters
`define AST_IDLE_FRAME     11'h7FF
`define AST_BREAK_FRAME    11'h000

`endif

//--- src/ast_baud_gen.v
`timescale 1ns/1ps
`include "ast_defs.vh"

// 13-bit modulo divider running on the bus clock; one x16 tick per period,
// one bit tick per sixteen x16 ticks; divisor zero stops it
module ast_baud_gen #(
  parameter DIV_W = `AST_DIV_W
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             run,
  input  wire [DIV_W-1:0] divisor,
  output reg              sampleTick_r,
  output reg              bitTick_r
);

  reg  [DIV_W-1:0] divCnt_r;
  reg  [3:0]       subCnt_r;
  wire             divWrap;

  assign divWrap = run && (divisor != {DIV_W{1'b0}}) &&
                   (divCnt_r >= divisor - {{(DIV_W-1){1'b0}}, 1'b1});

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      divCnt_r     <= {DIV_W{1'b0}};
      subCnt_r     <= 4'h0;
      sampleTick_r <= 1'b0;
      bitTick_r    <= 1'b0;
    end
    else
    begin
      sampleTick_r <= divWrap;
      bitTick_r    <= divWrap && (subCnt_r == `AST_OVERSAMPLE_MAX);
      if (!run || divisor == {DIV_W{1'b0}})
      begin
        divCnt_r <= {DIV_W{1'b0}};
        subCnt_r <= 4'h0;
      end
      else if (divWrap)
      begin
        divCnt_r <= {DIV_W{1'b0}};
        subCnt_r <= subCnt_r + 4'h1;
      end
      else
        divCnt_r <= divCnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // ast_baud_gen

//--- src/ast_pair_buf.v
`timescale 1ns/1ps

// two-entry buffer with valid/ready on both sides
module ast_pair_buf #(
  parameter WIDTH = 9
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             inValid,
  input  wire [WIDTH-1:0] inData,
  output wire             inReady,
  output wire             outValid,
  output wire [WIDTH-1:0] outData,
  input  wire             outReady
);

  reg  [WIDTH-1:0] mem [0:1];
  reg              wrPtr_r;
  reg              rdPtr_r;
  reg  [1:0]       count_r;
  wire             push;
  wire             pop;

  assign inReady  = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always @(posedge clk)
  begin
    if (push)
      mem[wrPtr_r] <= inData;
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else
    begin
      if (push)
        wrPtr_r <= ~wrPtr_r;
      if (pop)
        rdPtr_r <= ~rdPtr_r;
      if (push && !pop)
        count_r <= count_r + 2'h1;
      else if (pop && !push)
        count_r <= count_r - 2'h1;
    end
  end

endmodule // ast_pair_buf

//--- src/ast_transmitter.v
// Operation
// [R01] baud generator runs from the bus clock
// [R02] thirteen-bit modulo divider sets baud rate
// [R03] separate enables, one shared baud generator
// [R04] enabling transmitter queues one all-high preamble
// [R05] enabled and empty: line held high
// [R06] shifter holds ten or eleven bits
// [R07] start low, data LSB first, stop high
// [R08] data write fills transmit data buffer
// [R09] load shifter on bit tick, set buffer-empty
// [R10] status read then write clears buffer-empty
// [R11] nothing waiting after stop: set complete, idle
// [R12] complete only when everything sent, line high
// [R13] disable waits for data, idle, break; a character still in the buffer is not sent while tx_enable is low
// [R14] break is all zeros including stop
// [R15] pulsing send-break queues one break
// [R16] send-break still set at load: queue another
// [R17] toggling enable off then on queues idle
// [R18] pin held while shifter runs with enable low
// [R19] software drives spare pin high if released
// [R20] hardware parity bit on transmit when enabled
// [R21] buffer-empty and complete exposed as events
// [R22] buffer-empty interrupt requested while flag set
`timescale 1ns/1ps
`include "ast_defs.vh"

module ast_transmitter #(
  parameter DIV_W = `AST_DIV_W
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             tx_enable,
  input  wire             rx_enable,
  input  wire             send_break,
  input  wire             nineBitMode,
  input  wire             parityEnable,
  input  wire             parityOdd,
  input  wire [DIV_W-1:0] baudDivisor,
  input  wire             tx_buffer_empty_irq_enable,
  input  wire             tx_complete_irq_enable,
  input  wire             statusRead,
  input  wire             dataWrValid,
  input  wire [8:0]       dataWrChar,
  output reg              dataWrReady_r,
  output reg              tx_buffer_empty_flag_r,
  output reg              tx_complete_flag_r,
  output reg              txBufferEmptyIrq_r,
  output reg              txCompleteIrq_r,
  output reg              serial_out_pin_r,
  output reg              serialOutEnable_r,
  output reg              rxSampleTick_r
);

  localparam ST_IDLE  = 2'b01;
  localparam ST_SHIFT = 2'b10;

  // builds the shifter image: start, data LSB first, optional parity, stop
  function [10:0] buildFrame;
    input [8:0] d;
    input       nine;
    input       parEn;
    input       parOdd;
    reg   [8:0] pd;
    begin
      pd = d;
      if (parEn && nine)
        pd[`AST_PAR9_POS] = ^d[7:0] ^ parOdd; // [R20]
      else if (parEn)
        pd[`AST_PAR8_POS] = ^d[6:0] ^ parOdd; // [R20]
      if (nine)
        buildFrame = {`AST_MARK, pd[8:0], `AST_SPACE}; // [R07]
      else
        buildFrame = {`AST_MARK, `AST_MARK, pd[7:0], `AST_SPACE}; // [R07]
    end
  endfunction

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [10:0] shift_r;
  reg  [10:0] shift_nxt;
  reg  [3:0]  bitsLeft_r;
  reg  [3:0]  bitsLeft_nxt;
  reg         lineOut_nxt;
  reg         idleQ_r;
  reg         idleQ_nxt;
  reg         breakQ_r;
  reg         breakQ_nxt;
  reg         txEnPrev_r;
  reg         brkPrev_r;
  reg         readArm_r;
  reg         readArm_nxt;
  reg         tx_buffer_empty_flag_nxt;
  reg         tc_nxt;
  reg         loadData;
  reg         loadAny;
  wire        bufInReady;
  wire        bufOutValid;
  wire [8:0]  bufOutData;
  wire        sampleTick;
  wire        bitTick;
  wire        baudRun;
  wire        writeTaken;
  wire [3:0]  frameLen;

  assign frameLen   = nineBitMode ? `AST_FRAME9_BITS : `AST_FRAME8_BITS; // [R06]
  assign writeTaken = dataWrValid && bufInReady;
  assign baudRun    = tx_enable || rx_enable || (state_r == ST_SHIFT) ||
                      idleQ_r || breakQ_r; // [R03]

  // bus-clock divider shared with the receiver
  ast_baud_gen #(
    .DIV_W        (DIV_W)
  ) u_baud (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .run          (baudRun),
    .divisor      (baudDivisor),
    .sampleTick_r (sampleTick),
    .bitTick_r    (bitTick)
  ); // [R01] [R02]

  // transmit data buffer; a full buffer stalls the writer
  ast_pair_buf #(
    .WIDTH    (9)
  ) u_buf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (dataWrValid),
    .inData   (dataWrChar),
    .inReady  (bufInReady),
    .outValid (bufOutValid),
    .outData  (bufOutData),
    .outReady (loadData)
  ); // [R08]

  // shifter sequencing, special characters take priority over data
  always @*
  begin
    state_nxt    = state_r;
    shift_nxt    = shift_r;
    bitsLeft_nxt = bitsLeft_r;
    lineOut_nxt  = serial_out_pin_r;
    idleQ_nxt    = idleQ_r;
    breakQ_nxt   = breakQ_r;
    loadData     = 1'b0;
    loadAny      = 1'b0;
    if (tx_enable && !txEnPrev_r)
      idleQ_nxt = 1'b1; // [R04] [R17]
    if (send_break && !brkPrev_r)
      breakQ_nxt = 1'b1; // [R15]
    case (state_r)
      ST_IDLE:
      begin
        if (bitTick)
        begin
          if (breakQ_r)
          begin
            loadAny    = 1'b1;
            shift_nxt  = `AST_BREAK_FRAME; // [R14]
            breakQ_nxt = send_break; // [R16]
          end
          else if (idleQ_r)
          begin
            loadAny   = 1'b1;
            shift_nxt = `AST_IDLE_FRAME;
            idleQ_nxt = 1'b0;
          end
          else if (bufOutValid && tx_enable)
          begin
            loadAny   = 1'b1;
            loadData  = 1'b1; // [R09]
            shift_nxt = buildFrame(bufOutData, nineBitMode, parityEnable, parityOdd);
          end
          if (loadAny)
          begin
            lineOut_nxt  = shift_nxt[`AST_START_POS];
            shift_nxt    = {`AST_MARK, shift_nxt[10:1]};
            bitsLeft_nxt = frameLen - 4'h1;
            state_nxt    = ST_SHIFT;
          end
          else
            lineOut_nxt = `AST_MARK; // [R05] [R11]
        end
      end
      ST_SHIFT:
      begin
        if (bitTick)
        begin
          if (bitsLeft_r != 4'h0)
          begin
            lineOut_nxt  = shift_r[0]; // [R07]
            shift_nxt    = {`AST_MARK, shift_r[10:1]};
            bitsLeft_nxt = bitsLeft_r - 4'h1;
          end
          else
          begin
            // last bit has served its full time; line returns to mark
            lineOut_nxt = `AST_MARK;
            state_nxt   = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_nxt   = ST_IDLE;
        lineOut_nxt = `AST_MARK;
      end
    endcase
  end

  // flag handling: buffer-empty hardware set wins over the software clear; for complete, any clear wins over the set
  always @*
  begin
    tx_buffer_empty_flag_nxt    = tx_buffer_empty_flag_r;
    readArm_nxt = readArm_r;
    if (statusRead && tx_buffer_empty_flag_r)
      readArm_nxt = 1'b1; // [R10]
    if (writeTaken && readArm_r)
    begin
      tx_buffer_empty_flag_nxt    = 1'b0; // [R10]
      readArm_nxt = 1'b0;
    end
    if (loadData)
      tx_buffer_empty_flag_nxt = 1'b1; // [R09]
    tc_nxt = tx_complete_flag_r;
    if (loadAny || idleQ_nxt || breakQ_nxt || writeTaken)
      tc_nxt = 1'b0; // [R12]
    else if (state_r == ST_IDLE && bitTick && !bufOutValid)
      tc_nxt = 1'b1; // [R11] [R12]
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r                <= ST_IDLE;
      shift_r                <= `AST_IDLE_FRAME;
      bitsLeft_r             <= 4'h0;
      idleQ_r                <= 1'b0;
      breakQ_r               <= 1'b0;
      txEnPrev_r             <= 1'b0;
      brkPrev_r              <= 1'b0;
      readArm_r              <= 1'b0;
      serial_out_pin_r       <= `AST_MARK;
      serialOutEnable_r      <= 1'b0;
      tx_buffer_empty_flag_r <= `AST_TX_BUFFER_EMPTY_FLAG_RST;
      tx_complete_flag_r     <= `AST_TC_RST;
      txBufferEmptyIrq_r     <= 1'b0;
      txCompleteIrq_r        <= 1'b0;
      dataWrReady_r          <= 1'b0;
      rxSampleTick_r         <= 1'b0;
    end
    else
    begin
      state_r                <= state_nxt;
      shift_r                <= shift_nxt;
      bitsLeft_r             <= bitsLeft_nxt;
      idleQ_r                <= idleQ_nxt;
      breakQ_r               <= breakQ_nxt;
      txEnPrev_r             <= tx_enable;
      brkPrev_r              <= send_break;
      readArm_r              <= readArm_nxt;
      serial_out_pin_r       <= lineOut_nxt;
      // pin stays owned while tx_enable is high, a character is shifting or a special is queued
      serialOutEnable_r      <= tx_enable || (state_nxt == ST_SHIFT) ||
                                idleQ_nxt || breakQ_nxt; // [R13] [R18]
      tx_buffer_empty_flag_r <= tx_buffer_empty_flag_nxt; // [R21]
      tx_complete_flag_r     <= tc_nxt; // [R21]
      txBufferEmptyIrq_r     <= tx_buffer_empty_flag_nxt && tx_buffer_empty_irq_enable; // [R22]
      txCompleteIrq_r        <= tc_nxt && tx_complete_irq_enable;
      dataWrReady_r          <= bufInReady;
      rxSampleTick_r         <= sampleTick && rx_enable; // [R03]
    end
  end

endmodule // ast_transmitter

//--- test/ast_remote_rx.sv
`timescale 1ns/1ps

// remote receiver: samples mid-bit after each start-bit falling edge
module ast_remote_rx (
  input  wire        clk,
  input  wire        line,
  input  wire [12:0] div,
  input  wire        nine,
  output reg         frameDone,
  output reg  [10:0] frameBits
);
  integer k;
  initial frameDone = 1'b0;
  initial frameBits = 11'h000;
  always
    begin
      @(negedge line);
      frameBits = 11'h000;
      repeat (8 * div) @(posedge clk);
      for (k = 0; k < (nine ? 11 : 10); k = k + 1)
        begin
          frameBits[k] = line;
          if (k < (nine ? 10 : 9))
            repeat (16 * div) @(posedge clk);
        end
      frameDone <= 1'b1;
      @(posedge clk);
      frameDone <= 1'b0;
    end
endmodule // ast_remote_rx

//--- test/ast_transmitter_test.sv
`timescale 1ns/1ps
`include "ast_defs.vh"

module ast_transmitter_test;
  reg                  clk = 0, sys_rst = 1, tx_enable = 0, rx_enable = 0, send_break = 0;
  reg                  nineBitMode = 0, parityEnable = 0, parityOdd = 0, statusRead = 0;
  reg                  tx_buffer_empty_irq_enable = 0, tx_complete_irq_enable = 0, dataWrValid = 0;
  reg [`AST_DIV_W-1:0] baudDivisor = 13'h0002;
  reg [8:0]            dataWrChar = 9'h000;
  wire                 dataWrReady_r, tx_buffer_empty_flag_r, tx_complete_flag_r;
  wire                 txBufferEmptyIrq_r, txCompleteIrq_r, rxSampleTick_r;
  wire                 serial_out_pin_r, serialOutEnable_r, frameDone;
  wire [10:0]          frameBits;
  wire                 line = serialOutEnable_r ? serial_out_pin_r : 1'b1;
  integer              mismatches = 0, samples_checked = 0, m, ticks;
  reg [31:0]           seed = 32'hB46E;
  reg [10:0]           expQ[$];

  ast_transmitter ast_transmitter_i (.*);
  ast_remote_rx ast_remote_rx_i (.clk(clk), .line(line), .div(baudDivisor), .nine(nineBitMode),
    .frameDone(frameDone), .frameBits(frameBits));

  initial forever #5 clk = ~clk;

  function [8:0] rnd;
    input dummy;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed[8:0];
    end
  endfunction

  // expected line image: start 0, data lsb first, stop 1
  function [10:0] frm(input [8:0] c);
    reg [8:0] d;
    begin
      d = c;
      if (parityEnable && !nineBitMode)
        d[7] = ^c[6:0] ^ parityOdd;
      if (parityEnable && nineBitMode)
        d[8] = ^c[7:0] ^ parityOdd;
      frm = nineBitMode ? {1'b1, d, 1'b0} : {2'b01, d[7:0], 1'b0};
    end
  endfunction

  function ok(input integer w);
    ok = w == 0 ? (tx_complete_flag_r === 1'b1 && expQ.size() == 0) :
         w == 1 ? serial_out_pin_r === 1'b0 : dataWrReady_r === 1'b1;
  endfunction

  task report_and_stop;
    begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input string nm, input [10:0] exp, input [10:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
        begin
          mismatches = mismatches + 1;
          $display("ERROR %0s expected %h seen %h", nm, exp, got);
        end
    end
  endtask

  task waitUntil(input integer w);
    integer n;
    begin
      n = 0;
      while (!ok(w) && n < 6000)
        begin
          @(negedge clk);
          n = n + 1;
        end
      if (n >= 6000)
        begin
          chk("wait", 0, 1);
          report_and_stop;
        end
    end
  endtask

  // one write only after ready seen, then a spare cycle
  task wr(input [8:0] c);
    begin
      waitUntil(2);
      dataWrValid = 1;
      dataWrChar = c;
      expQ.push_back(frm(c));
      @(negedge clk);
      dataWrValid = 0;
      @(negedge clk);
      chk("complete", 0, tx_complete_flag_r);
    end
  endtask

  always @(posedge clk)
    if (frameDone)
      chk("frame", expQ.size() ? expQ.pop_front() : 11'h7FF, frameBits);

  initial
    begin
      repeat (8) @(negedge clk);
      sys_rst = 0;
      @(negedge clk);
      chk("pin", `AST_MARK, serial_out_pin_r);
      chk("empty", `AST_TX_BUFFER_EMPTY_FLAG_RST, tx_buffer_empty_flag_r);
      chk("complete", `AST_TC_RST, tx_complete_flag_r);
      tx_enable = 1;
      rx_enable = 1;
      tx_buffer_empty_irq_enable = 1;
      tx_complete_irq_enable = 1;
      waitUntil(0);
      for (m = 0; m < 4; m = m + 1)
        begin
          nineBitMode = m[1];
          parityEnable = m != 0;
          parityOdd = m[1] & !m[0];
          tx_complete_irq_enable = rnd(0) & 9'h001;
          wr(rnd(0));
          wr(rnd(0));
          waitUntil(0);
          $display("test mode %0d done", m);
        end
      nineBitMode = 0;
      parityEnable = 0;
      wr(rnd(0));
      chk("empty", 1, tx_buffer_empty_flag_r);
      waitUntil(1);
      statusRead = 1;
      @(negedge clk);
      statusRead = 0;
      wr(rnd(0));
      chk("empty", 0, tx_buffer_empty_flag_r);
      wr(rnd(0));
      chk("ready", 0, dataWrReady_r);
      wr(rnd(0));
      waitUntil(0);
      $display("test buffer done");
      send_break = 1;
      @(negedge clk);
      send_break = 0;
      expQ.push_back(`AST_BREAK_FRAME);
      waitUntil(0);
      $display("test break done");
      send_break = 1;
      waitUntil(1);
      send_break = 0;
      expQ.push_back(`AST_BREAK_FRAME);
      expQ.push_back(`AST_BREAK_FRAME);
      waitUntil(0);
      $display("test held break done");
      wr(rnd(0));
      tx_enable = 0;
      @(negedge clk);
      tx_enable = 1;
      wr(rnd(0));
      waitUntil(0);
      wr(rnd(0));
      waitUntil(1);
      tx_enable = 0;
      waitUntil(0);
      repeat (2) @(negedge clk);
      chk("pin owner", 0, serialOutEnable_r);
      chk("empty request", 1, txBufferEmptyIrq_r);
      chk("complete request", tx_complete_irq_enable, txCompleteIrq_r);
      $display("test disable done");
      for (m = 0; m < 2; m = m + 1)
        begin
          rx_enable = m == 0;
          ticks = 0;
          repeat (64)
            begin
              @(negedge clk);
              ticks = ticks + rxSampleTick_r;
            end
          chk("rx ticks", m == 0 ? 64 / baudDivisor : 0, ticks);
        end
      $display("test receiver tick done");
      report_and_stop;
    end
endmodule // ast_transmitter_test

//--- test/ast_tx_properties.sv
`timescale 1ns/1ps

module ast_tx_properties #(
  parameter DIV_W = 13
) (
  input wire             clk,
  input wire             sys_rst,
  input wire             tx_enable,
  input wire             rx_enable,
  input wire             send_break,
  input wire             nineBitMode,
  input wire             parityEnable,
  input wire             parityOdd,
  input wire [DIV_W-1:0] baudDivisor,
  input wire             tx_buffer_empty_irq_enable,
  input wire             tx_complete_irq_enable,
  input wire             statusRead,
  input wire             dataWrValid,
  input wire [8:0]       dataWrChar,
  input wire             dataWrReady_r,
  input wire             tx_buffer_empty_flag_r,
  input wire             tx_complete_flag_r,
  input wire             txBufferEmptyIrq_r,
  input wire             txCompleteIrq_r,
  input wire             serial_out_pin_r,
  input wire             serialOutEnable_r,
  input wire             rxSampleTick_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_EMPTY_IRQ_ON: assert property (
    (tx_buffer_empty_flag_r && tx_buffer_empty_irq_enable) [*2] |-> txBufferEmptyIrq_r)
    else $error("buffer-empty request missing");
  AST_EMPTY_IRQ_OFF: assert property (
    (!tx_buffer_empty_flag_r || !tx_buffer_empty_irq_enable) [*2] |-> !txBufferEmptyIrq_r)
    else $error("buffer-empty request without cause");
  AST_DONE_IRQ: assert property (
    (tx_complete_flag_r && tx_complete_irq_enable) [*2] |-> txCompleteIrq_r)
    else $error("complete request missing");
  AST_DONE_LINE_HIGH: assert property (tx_complete_flag_r |-> serial_out_pin_r)
    else $error("complete while line low");
  AST_DONE_AFTER_STOP: assert property ($rose(tx_complete_flag_r) |-> $past(serial_out_pin_r))
    else $error("complete not after a stop bit");
  AST_START_LENGTH: assert property (
    $fell(serial_out_pin_r) |-> !serial_out_pin_r [*8] ##1 !serial_out_pin_r [*8])
    else $error("start bit too short");
  AST_HOLD_PIN: assert property (
    serialOutEnable_r && !serial_out_pin_r |=> serialOutEnable_r)
    else $error("pin released in mid-frame");
  AST_LOAD_START: assert property ($rose(tx_buffer_empty_flag_r) |-> !serial_out_pin_r)
    else $error("buffer-empty set without a start bit");
  AST_EMPTY_CLEAR: assert property ($fell(tx_buffer_empty_flag_r) |-> $past(dataWrValid))
    else $error("buffer-empty cleared without a write");
  AST_WRITE_DONE_LOW: assert property (
    dataWrValid && dataWrReady_r && !$past(dataWrValid) |=> !tx_complete_flag_r)
    else $error("complete still set after a write");
  AST_RX_TICK_GATE: assert property (!rx_enable [*2] |-> !rxSampleTick_r)
    else $error("receiver tick while receiver off");

  cover property ($rose(tx_complete_flag_r));
  cover property ($fell(tx_buffer_empty_flag_r));
  cover property ($fell(serialOutEnable_r));
endmodule // ast_tx_properties

bind ast_transmitter ast_tx_properties #(.DIV_W(DIV_W)) ast_tx_properties_i (.*);
